// ---- common/slso_pkg.sv ----
package slso_pkg;

  // Register byte offsets
  localparam logic [11:0] SLSO_OFS_DFLT_STAT = 12'h000;
  localparam logic [11:0] SLSO_OFS_OUT_STAT = 12'h004;
  localparam logic [11:0] SLSO_OFS_RX_TX_OVERRIDE_ENABLE = 12'h008;

  // Default status register fields
  localparam int SLSO_STAT_TOP_LSB = 30;
  localparam logic [1:0] SLSO_STAT_TOP_VAL = 2'h1;
  localparam int SLSO_STAT_LOS_LSB = 28;
  localparam int SLSO_STAT_EQ_LSB = 21;
  localparam int SLSO_STAT_ALIGN_BIT = 19;
  localparam int SLSO_STAT_HALF_BIT = 16;
  localparam int SLSO_STAT_MID_LSB = 10;
  localparam logic [5:0] SLSO_STAT_MID_VAL = 6'h20;
  localparam int SLSO_STAT_BOOST_LSB = 6;

  // Output status and transmit override register fields
  localparam int SLSO_OUT_EN_BIT = 31;
  localparam int SLSO_OUT_RSV_LSB = 26;
  localparam int SLSO_OUT_BOOST_LSB = 22;
  localparam int SLSO_OUT_KEEP_LSB = 3;
  localparam int SLSO_OUT_LOSS_BIT = 2;
  localparam logic [4:0] SLSO_OUT_RSV_RST = 5'h00;
  localparam logic [3:0] SLSO_OUT_BOOST_RST = 4'h0;
  localparam logic [18:0] SLSO_OUT_KEEP_RST = 19'h00000;

  // Receive override register fields
  localparam int SLSO_RX_EN_BIT = 14;
  localparam int SLSO_RX_LOS_LSB = 12;
  localparam int SLSO_RX_KEEP_HI_LSB = 8;
  localparam int SLSO_RX_EQ_LSB = 5;
  localparam int SLSO_RX_KEEP_MID_BIT = 4;
  localparam int SLSO_RX_ALIGN_BIT = 3;
  localparam int SLSO_RX_KEEP_LO_LSB = 1;
  localparam int SLSO_RX_HALF_BIT = 0;
  localparam logic [1:0] SLSO_RX_LOS_RST = 2'h1;
  localparam logic [3:0] SLSO_RX_KEEP_HI_RST = 4'h0;
  localparam logic [2:0] SLSO_RX_EQ_RST = 3'h0;
  localparam logic SLSO_RX_KEEP_MID_RST = 1'b1;
  localparam logic SLSO_RX_ALIGN_RST = 1'b1;
  localparam logic [1:0] SLSO_RX_KEEP_LO_RST = 2'h3;
  localparam logic SLSO_RX_HALF_RST = 1'b0;

endpackage : slso_pkg

// ---- verilog/slso_tx_override_enable_sel.sv ----
`timescale 1ns/1ps
module slso_tx_override_enable_sel #(
  parameter int W = 4
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_tx_override_enable_en,
  input wire logic [W-1:0] i_dflt,
  input wire logic [W-1:0] i_tx_override_enable,
  output logic [W-1:0] o_sel
);

  wire logic [W-1:0] sel_nxt;

  assign sel_nxt = i_tx_override_enable_en ? i_tx_override_enable : i_dflt;

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_sel <= '0;
    else
      o_sel <= sel_nxt;
  end

endmodule : slso_tx_override_enable_sel

// ---- verilog/slso_lane_regs.sv ----
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Status register holds lane control defaults captured at power-up, read-only.
// - Status fields keep defaults once overridden, so no longer show driven value.
// - Output status bit 31 enables override by writable bits 22 to 25.
// - Boost override field 25:22 drives lane boost while enabled; resets zero.
// - Boost code maps to dB by formula; code zero means no boost.
// - Output status bit 2 reflects lane signal loss; writes ignored.
// - Status fields: filter 29:28, equalizer 23:21, half-rate 16, boost 9:6.
// - Receive override enable bit 14 replaces filter, equalizer, alignment settings.
module slso_lane_regs
  import slso_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [11:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [1:0] i_dflt_signal_loss_filter_mode,
  input wire logic [2:0] i_dflt_receive_equalizer_setting,
  input wire logic i_dflt_rx_align_en,
  input wire logic i_dflt_half_rate,
  input wire logic [3:0] i_dflt_tx_boost,
  input wire logic i_signal_loss_indicator,
  output logic [3:0] o_lane_tx_boost,
  output logic o_lane_tx_boost_en,
  output logic [1:0] o_lane_signal_loss_filter_mode,
  output logic [2:0] o_lane_receive_equalizer_setting,
  output logic o_lane_rx_align_en,
  output logic o_lane_half_rate
);

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
    addr_is = (a == ofs);
  endfunction : addr_is

  // Captured power-up defaults
  logic cap_done_r;
  logic [1:0] dflt_los_r;
  logic [2:0] dflt_eq_r;
  logic dflt_align_r;
  logic dflt_half_r;
  logic [3:0] dflt_boost_r;
  logic sig_loss_r;

  // Transmit override register
  logic tx_override_enable_r;
  logic [4:0] out_rsv_r;
  logic [3:0] boost_tx_override_enable_r;
  logic [18:0] preserve_on_write_reserved_r;

  // Receive override register
  logic rx_override_enable_r;
  logic [1:0] rx_los_r;
  logic [3:0] rx_keep_hi_r;
  logic [2:0] rx_eq_r;
  logic rx_keep_mid_r;
  logic rx_align_r;
  logic [1:0] rx_keep_lo_r;
  logic rx_half_r;

  // Bus slave
  logic [31:0] rdata_nxt;
  wire logic req;
  wire logic wr_done;
  wire logic sel_stat;
  wire logic sel_out;
  wire logic sel_rx;
  wire logic [31:0] stat_word;
  wire logic [31:0] out_word;
  wire logic [31:0] rx_word;
  wire logic [4:0] tx_dflt_vec;
  wire logic [4:0] tx_tx_override_enable_vec;
  wire logic [4:0] tx_out_vec;
  wire logic [6:0] rx_dflt_vec;
  wire logic [6:0] rx_tx_override_enable_vec;
  wire logic [6:0] rx_out_vec;

  // One wait cycle: data is loaded while waitrequest is high, taken when it drops
  assign req = i_avs_read | i_avs_write;
  assign wr_done = i_avs_write & ~o_avs_waitrequest;
  assign sel_stat = addr_is(i_avs_address, SLSO_OFS_DFLT_STAT);
  assign sel_out = addr_is(i_avs_address, SLSO_OFS_OUT_STAT);
  assign sel_rx = addr_is(i_avs_address, SLSO_OFS_RX_TX_OVERRIDE_ENABLE);

  // Defaults stay in the status word even when overridden
  assign stat_word = {SLSO_STAT_TOP_VAL, dflt_los_r, 4'h0, dflt_eq_r, 1'b0, dflt_align_r,
                      2'h0, dflt_half_r, SLSO_STAT_MID_VAL, dflt_boost_r, 6'h00};
  assign out_word = {tx_override_enable_r, out_rsv_r, boost_tx_override_enable_r,
                     preserve_on_write_reserved_r, sig_loss_r, 2'h0};
  assign rx_word = {17'h00000, rx_override_enable_r, rx_los_r, rx_keep_hi_r, rx_eq_r,
                    rx_keep_mid_r, rx_align_r, rx_keep_lo_r, rx_half_r};

  always_comb
  begin
    rdata_nxt = 32'h00000000;
    if (sel_stat)
      rdata_nxt = stat_word;
    else if (sel_out)
      rdata_nxt = out_word;
    else if (sel_rx)
      rdata_nxt = rx_word;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
    end
    else
    begin
      o_avs_waitrequest <= ~(req & o_avs_waitrequest);
      o_avs_readdata <= rdata_nxt;
    end
  end

  // Defaults are sampled on the first edge after reset release, not under reset
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cap_done_r <= 1'b0;
      dflt_los_r <= 2'h0;
      dflt_eq_r <= 3'h0;
      dflt_align_r <= 1'b0;
      dflt_half_r <= 1'b0;
      dflt_boost_r <= 4'h0;
    end
    else if (!cap_done_r)
    begin
      cap_done_r <= 1'b1;
      dflt_los_r <= i_dflt_signal_loss_filter_mode;
      dflt_eq_r <= i_dflt_receive_equalizer_setting;
      dflt_align_r <= i_dflt_rx_align_en;
      dflt_half_r <= i_dflt_half_rate;
      dflt_boost_r <= i_dflt_tx_boost;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      sig_loss_r <= 1'b0;
    else
      sig_loss_r <= i_signal_loss_indicator;
  end

  // Bit 2 is loaded from the loss indicator and bits 1:0 are constant zero, so writes cannot touch them
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tx_override_enable_r <= 1'b0;
      out_rsv_r <= SLSO_OUT_RSV_RST;
      boost_tx_override_enable_r <= SLSO_OUT_BOOST_RST;
      preserve_on_write_reserved_r <= SLSO_OUT_KEEP_RST;
    end
    else if (wr_done && sel_out)
    begin
      tx_override_enable_r <= i_avs_writedata[SLSO_OUT_EN_BIT];
      out_rsv_r <= i_avs_writedata[SLSO_OUT_RSV_LSB +: 5];
      boost_tx_override_enable_r <= i_avs_writedata[SLSO_OUT_BOOST_LSB +: 4];
      // Stores whatever software wrote back after its read
      preserve_on_write_reserved_r <= i_avs_writedata[SLSO_OUT_KEEP_LSB +: 19];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rx_override_enable_r <= 1'b0;
      rx_los_r <= SLSO_RX_LOS_RST;
      rx_keep_hi_r <= SLSO_RX_KEEP_HI_RST;
      rx_eq_r <= SLSO_RX_EQ_RST;
      rx_keep_mid_r <= SLSO_RX_KEEP_MID_RST;
      rx_align_r <= SLSO_RX_ALIGN_RST;
      rx_keep_lo_r <= SLSO_RX_KEEP_LO_RST;
      rx_half_r <= SLSO_RX_HALF_RST;
    end
    else if (wr_done && sel_rx)
    begin
      rx_override_enable_r <= i_avs_writedata[SLSO_RX_EN_BIT];
      rx_los_r <= i_avs_writedata[SLSO_RX_LOS_LSB +: 2];
      rx_keep_hi_r <= i_avs_writedata[SLSO_RX_KEEP_HI_LSB +: 4];
      rx_eq_r <= i_avs_writedata[SLSO_RX_EQ_LSB +: 3];
      rx_keep_mid_r <= i_avs_writedata[SLSO_RX_KEEP_MID_BIT];
      rx_align_r <= i_avs_writedata[SLSO_RX_ALIGN_BIT];
      rx_keep_lo_r <= i_avs_writedata[SLSO_RX_KEEP_LO_LSB +: 2];
      rx_half_r <= i_avs_writedata[SLSO_RX_HALF_BIT];
    end
  end

  // Code zero is flagged so the driver applies no boost at all
  assign tx_dflt_vec = {dflt_boost_r != 4'h0, dflt_boost_r};
  assign tx_tx_override_enable_vec = {boost_tx_override_enable_r != 4'h0, boost_tx_override_enable_r};
  assign rx_dflt_vec = {dflt_los_r, dflt_eq_r, dflt_align_r, dflt_half_r};
  // Half-rate stays on its default: the override covers filter, equalizer, alignment
  assign rx_tx_override_enable_vec = {rx_los_r, rx_eq_r, rx_align_r, dflt_half_r};

  slso_tx_override_enable_sel #(.W(5)) u_tx_sel (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_tx_override_enable_en(tx_override_enable_r),
    .i_dflt(tx_dflt_vec),
    .i_tx_override_enable(tx_tx_override_enable_vec),
    .o_sel(tx_out_vec)
  );

  slso_tx_override_enable_sel #(.W(7)) u_rx_sel (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_tx_override_enable_en(rx_override_enable_r),
    .i_dflt(rx_dflt_vec),
    .i_tx_override_enable(rx_tx_override_enable_vec),
    .o_sel(rx_out_vec)
  );

  assign o_lane_tx_boost_en = tx_out_vec[4];
  assign o_lane_tx_boost = tx_out_vec[3:0];
  assign o_lane_signal_loss_filter_mode = rx_out_vec[6:5];
  assign o_lane_receive_equalizer_setting = rx_out_vec[4:2];
  assign o_lane_rx_align_en = rx_out_vec[1];
  assign o_lane_half_rate = rx_out_vec[0];

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_wait;
    req && o_avs_waitrequest;
  endsequence

  sequence s_out_write;
    s_wait ##1 (i_avs_write && sel_out && !o_avs_waitrequest);
  endsequence

  sequence s_stat_read;
    s_wait ##1 (i_avs_read && sel_stat && !o_avs_waitrequest);
  endsequence

  bus_answer_a: assert property (s_wait |=> !o_avs_waitrequest)
    else $error("bus request not answered after one wait cycle");

  default_capture_a: assert property ($rose(cap_done_r) |->
      dflt_boost_r == $past(i_dflt_tx_boost)
      && dflt_los_r == $past(i_dflt_signal_loss_filter_mode))
    else $error("power-up defaults not captured");

  stat_fields_a: assert property (s_stat_read |->
      o_avs_readdata[9:6] == dflt_boost_r && o_avs_readdata[29:28] == dflt_los_r
      && o_avs_readdata[23:21] == dflt_eq_r && o_avs_readdata[16] == dflt_half_r)
    else $error("status read fields mismatch");

  stat_readonly_a: assert property ((wr_done && sel_stat && cap_done_r) |=>
      $stable(dflt_boost_r) && $stable(dflt_eq_r))
    else $error("status register changed by a write");

  tx_override_enable_enable_a: assert property (s_out_write |=>
      tx_override_enable_r == $past(i_avs_writedata[31])
      && boost_tx_override_enable_r == $past(i_avs_writedata[25:22]))
    else $error("override enable write not stored");

  boost_tx_override_enable_a: assert property (tx_override_enable_r |=>
      o_lane_tx_boost == $past(boost_tx_override_enable_r))
    else $error("lane boost not taken from override");

  boost_dflt_a: assert property (!tx_override_enable_r |=>
      o_lane_tx_boost == $past(dflt_boost_r))
    else $error("lane boost not taken from default");

  boost_zero_a: assert property ((tx_override_enable_r && boost_tx_override_enable_r == 4'h0) |=>
      !o_lane_tx_boost_en)
    else $error("boost enable disagrees with boost code");

  loss_read_a: assert property ((i_avs_read && sel_out && !o_avs_waitrequest) |->
      o_avs_readdata[2] == $past(sig_loss_r))
    else $error("signal loss bit not reflected");

  rx_tx_override_enable_a: assert property (rx_override_enable_r |=>
      o_lane_receive_equalizer_setting == $past(rx_eq_r)
      && o_lane_rx_align_en == $past(rx_align_r))
    else $error("receive override not applied");

endmodule : slso_lane_regs

// ---- tb/slso_lane_model.sv ----
`timescale 1ns/1ps
module slso_lane_model #(
  parameter logic [1:0] FILT = 2'h3,
  parameter logic [2:0] EQ = 3'h2,
  parameter logic ALIGN = 1'b1,
  parameter logic HALF = 1'b1,
  parameter logic [3:0] BOOST = 4'hB
) (
  input wire logic i_core_clk,
  input wire logic i_loss_req,
  output logic [1:0] o_dflt_filt,
  output logic [2:0] o_dflt_eq,
  output logic o_dflt_align,
  output logic o_dflt_half,
  output logic [3:0] o_dflt_boost,
  output logic o_signal_loss_indicator
);
  // Straps never move, so the captured defaults stay the lane's true power-up state
  assign o_dflt_filt = FILT;
  assign o_dflt_eq = EQ;
  assign o_dflt_align = ALIGN;
  assign o_dflt_half = HALF;
  assign o_dflt_boost = BOOST;
  initial o_signal_loss_indicator = 1'b0;
  always @(posedge i_core_clk)
  begin
    o_signal_loss_indicator <= i_loss_req;
  end
endmodule : slso_lane_model

// ---- tb/test_serdes_lane_status_override.sv ----
`timescale 1ns/1ps
module test_serdes_lane_status_override;
  import slso_pkg::*;
  localparam logic [31:0] STAT_EXP = {2'h1, 2'h3, 4'h0, 3'h2, 1'b0, 1'b1, 2'h0, 1'b1, 6'h20,
    4'hB, 6'h00};
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [11:0] adr = 12'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic loss_req = 1'b0;
  logic [31:0] rdata, q, d, out_m, rx_m;
  logic waitr, signal_loss_indicator, bst_en, align, half, d_align, d_half;
  logic [3:0] bst, d_bst;
  logic [1:0] filt, d_filt;
  logic [2:0] eq, d_eq;
  logic [31:0] tbl [2] = '{32'h000040A1, 32'hFFFF3F5E};
  integer seed = 32'hc120;
  int n_fail = 0;
  int check_count = 0;
  int i;

  always #5 i_core_clk = ~i_core_clk;

  slso_lane_model u_slso_lane_model (.i_core_clk(i_core_clk), .i_loss_req(loss_req),
    .o_dflt_filt(d_filt), .o_dflt_eq(d_eq), .o_dflt_align(d_align), .o_dflt_half(d_half),
    .o_dflt_boost(d_bst), .o_signal_loss_indicator(signal_loss_indicator));

  slso_lane_regs u_slso_lane_regs (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitr),
    .i_dflt_signal_loss_filter_mode(d_filt), .i_dflt_receive_equalizer_setting(d_eq),
    .i_dflt_rx_align_en(d_align), .i_dflt_half_rate(d_half), .i_dflt_tx_boost(d_bst),
    .i_signal_loss_indicator(signal_loss_indicator), .o_lane_tx_boost(bst), .o_lane_tx_boost_en(bst_en),
    .o_lane_signal_loss_filter_mode(filt), .o_lane_receive_equalizer_setting(eq),
    .o_lane_rx_align_en(align), .o_lane_half_rate(half));

  task finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("MISMATCH %s exp %h got %h", n, e, g);
      n_fail++;
    end
  endtask : chk_reg

  task chk_lane(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("MISMATCH %s exp %h got %h", n, e, g);
      n_fail++;
    end
  endtask : chk_lane

  // Request held until waitrequest is sampled low; one idle edge before the next request
  task bus(input logic w, input logic [11:0] a, input logic [31:0] dat);
    int n;
    adr <= a;
    wd <= dat;
    wr <= w;
    rd <= !w;
    n = 0;
    do
    begin
      @(posedge i_core_clk);
      n++;
    end
    while (waitr !== 1'b0 && n < 20);
    q = rdata;
    if (n >= 20)
    begin
      n_fail++;
      finish_test();
    end
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge i_core_clk);
  endtask : bus

  // Lane outputs move one edge after the write lands; sample them at the edge after that
  task chk_out();
    logic [3:0] be;
    logic [5:0] re;
    @(posedge i_core_clk);
    be = out_m[31] ? out_m[25:22] : 4'hB;
    re = rx_m[14] ? {rx_m[13:12], rx_m[7:5], rx_m[3]} : {2'h3, 3'h2, 1'b1};
    chk_lane("tx_boost", {3'h0, be != 4'h0, be}, {3'h0, bst_en, bst});
    chk_lane("rx_ctl", {1'b0, re, 1'b1}, {1'b0, filt, eq, align, half});
  endtask : chk_out

  initial
  begin
    out_m = 32'h0;
    rx_m = 32'h0000101E;
    repeat (5) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    @(posedge i_core_clk);
    bus(1'b0, SLSO_OFS_DFLT_STAT, 32'h0);
    chk_reg("dflt_stat", STAT_EXP, q);
    bus(1'b0, SLSO_OFS_OUT_STAT, 32'h0);
    chk_reg("out_stat", 32'h0, q);
    bus(1'b0, SLSO_OFS_RX_TX_OVERRIDE_ENABLE, 32'h0);
    chk_reg("rx_tx_override_enable", 32'h0000101E, q);
    chk_out();
    $display("test reset done");
    for (i = 0; i < 8; i++)
    begin
      d = $random(seed);
      loss_req <= ~d[2];
      bus(1'b1, SLSO_OFS_DFLT_STAT, ~d);
      bus(1'b1, SLSO_OFS_OUT_STAT, d);
      out_m[31:3] = d[31:3];
      bus(1'b1, 12'h00C, d);
      bus(1'b0, 12'h00C, 32'h0);
      chk_reg("unmapped", 32'h0, q);
      bus(1'b0, SLSO_OFS_DFLT_STAT, 32'h0);
      chk_reg("dflt_stat", STAT_EXP, q);
      bus(1'b0, SLSO_OFS_OUT_STAT, 32'h0);
      chk_reg("out_stat", {out_m[31:3], ~d[2], 2'h0}, q);
      chk_out();
    end
    $display("test random done");
    for (i = 0; i < 16; i++)
    begin
      bus(1'b0, SLSO_OFS_OUT_STAT, 32'h0);
      d = {1'b1, q[30:26], i[3:0], q[21:0]};
      bus(1'b1, SLSO_OFS_OUT_STAT, d);
      out_m[31:3] = d[31:3];
      chk_out();
    end
    bus(1'b1, SLSO_OFS_OUT_STAT, {1'b0, out_m[30:3], 3'h0});
    out_m[31] = 1'b0;
    chk_out();
    $display("test boost done");
    for (i = 0; i < 2; i++)
    begin
      bus(1'b1, SLSO_OFS_RX_TX_OVERRIDE_ENABLE, tbl[i]);
      rx_m = tbl[i] & 32'h00007FFF;
      chk_out();
      bus(1'b0, SLSO_OFS_RX_TX_OVERRIDE_ENABLE, 32'h0);
      chk_reg("rx_tx_override_enable", rx_m, q);
    end
    $display("test rx override done");
    finish_test();
  end
endmodule : test_serdes_lane_status_override
